// *** verif/srg_host.sv ***
// AXI4-Lite host model that programs the register bank
`timescale 1ns/100ps
`default_nettype none
module srg_host
   import srg_pkg::*;
(
   input wire logic ref_clk,
   output logic [SRG_AW-1:0] s_axi_awaddr = '0,
   output logic s_axi_awvalid = 1'b0,
   input wire logic s_axi_awready,
   output logic [SRG_DW-1:0] s_axi_wdata = '0,
   output logic [3:0] s_axi_wstrb = 4'h0,
   output logic s_axi_wvalid = 1'b0,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready = 1'b0,
   output logic [SRG_AW-1:0] s_axi_araddr = '0,
   output logic s_axi_arvalid = 1'b0,
   input wire logic s_axi_arready,
   input wire logic [SRG_DW-1:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready = 1'b0
);
   // Taken address and data flip to their inverse, so a slave that
   // samples late sees garbage instead of a lucky stale match
   task automatic wr(input logic [5:0] idx, input logic [7:0] d, output logic [1:0] resp);
      @(posedge ref_clk);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
         @(posedge ref_clk);
      while (s_axi_awready !== 1'b1 || s_axi_wready !== 1'b1);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      s_axi_awaddr <= ~s_axi_awaddr;
      s_axi_wdata <= ~s_axi_wdata;
      do
         @(posedge ref_clk);
      while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] resp);
      @(posedge ref_clk);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
         @(posedge ref_clk);
      while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      s_axi_araddr <= ~s_axi_araddr;
      do
         @(posedge ref_clk);
      while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
endmodule : srg_host
`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking bench for the sensor readout register bank
`timescale 1ns/100ps
`default_nettype none
module tb_top
   import srg_pkg::*;
();
   localparam int W = 4;
   localparam int G = 209;
   localparam int H = 3;
   localparam int F = 2;
   localparam int DIV = SRG_SENS_DIV;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic auto_exposure_en = 1'b0;
   logic exp_more = 1'b0;
   logic exp_less = 1'b0;
   logic [SRG_AW-1:0] s_axi_awaddr, s_axi_araddr;
   logic [SRG_DW-1:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, vsync, hsync, pix_valid;
   logic [8:0] row_addr;
   logic [9:0] col_addr;
   logic [SRG_CGAIN_W-1:0] red_gain, green_gain, blue_gain;
   logic [7:0] amp_gain;
   logic [SRG_BIAS_W-1:0] pixel_bias, amp_bias;
   logic [SRG_NIB_W-1:0] clamp_level, adc_bias;
   logic [15:0] integ_time;
   int n_errors = 0;
   int samples_checked = 0;
   int hs_bad = 0;
   int exp_bad = 0;

   srg_regs i_dut (.ref_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .auto_exposure_en, .exp_more, .exp_less, .vsync, .hsync, .pix_valid,
      .row_addr,
      .col_addr, .red_gain, .green_gain, .blue_gain, .amp_gain, .pixel_bias, .amp_bias,
      .clamp_level, .adc_bias, .integ_time);
   srg_host i_host (.ref_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);

   always #12.5 ref_clk = ~ref_clk;

   task automatic print_verdict;
      if (n_errors == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic cfg(input logic [5:0] idx, input int v);
      logic [1:0] r;
      i_host.wr(idx, 8'(v), r);
      chk(r, SRG_RESP_OKAY);
   endtask : cfg

   task automatic rb(input logic rst);
      logic [31:0] d;
      logic [1:0] r;
      for (int i = 0; i < SRG_NREG; i++)
      begin
         i_host.rd(SRG_IDX[i], d, r);
         chk({r, d}, {SRG_RESP_OKAY, 24'h0, rst ? SRG_RST[i] : 8'hA5 & SRG_MASK[i]});
      end
   endtask : rb

   // Waits for the level, then measures its run; capture is taken on its first cycle
   task automatic span(input logic sel, output int w, output int n, output logic [19:0] cap);
      w = 0;
      n = 0;
      while ((sel ? vsync : pix_valid) !== 1'b1)
      begin
         w++;
         @(posedge ref_clk);
      end
      cap = {hsync, row_addr, col_addr};
      while ((sel ? vsync : pix_valid) === 1'b1)
      begin
         n++;
         if (sel && hsync !== 1'b0)
            hs_bad++;
         @(posedge ref_clk);
      end
   endtask : span

   // Written early, while the post-reset blank line is still short of the new counts
   task automatic t_video;
      int w;
      int n;
      logic [19:0] cap;
      cfg(6'h08, 8'h01);
      cfg(6'h09, 8'h05);
      cfg(6'h0A, 8'h02);
      cfg(6'h0B, 8'h03);
      cfg(6'h0C, 0);
      cfg(6'h0D, H);
      cfg(6'h0E, 0);
      cfg(6'h0F, W);
      cfg(6'h11, G);
      cfg(6'h13, F);
      span(1'b1, w, n, cap);
      for (int r = 0; r < H; r++)
      begin
         span(1'b0, w, n, cap);
         chk(cap[18:10], 9'(9'h105 + r));
         chk(cap[9:0], 10'h203);
         chk(cap[19], 1'b1);
         chk(n, W * DIV);
         if (r > 0)
            chk(w, G * DIV);
      end
      span(1'b1, w, n, cap);
      chk(w <= G * DIV, 1'b1);
      chk(n, F * (W + G) * DIV);
      chk(hs_bad, 0);
      span(1'b0, w, n, cap);
      chk(cap[18:10], 9'h105);
   endtask : t_video

   task automatic exp_run(input logic m, input logic l, input int n);
      @(posedge ref_clk);
      exp_more <= m;
      exp_less <= l;
      repeat (n)
      begin
         @(posedge ref_clk);
         if (amp_gain > 8'h14)
            exp_bad++;
      end
      exp_more <= 1'b0;
      exp_less <= 1'b0;
      @(posedge ref_clk);
   endtask : exp_run

   task automatic t_exposure;
      logic [31:0] d;
      logic [1:0] r;
      cfg(6'h18, 8'h00);
      cfg(6'h19, 8'h14);
      cfg(6'h1A, 8'h12);
      auto_exposure_en <= 1'b1;
      exp_run(1'b1, 1'b0, 256);
      chk({integ_time, amp_gain}, {16'h0200, 8'h10});
      // Both requests at once cancel, so nothing may move
      exp_run(1'b1, 1'b1, 4);
      chk({integ_time, amp_gain}, {16'h0200, 8'h10});
      exp_run(1'b1, 1'b0, 1);
      chk(amp_gain, 8'h12);
      exp_run(1'b1, 1'b0, 20);
      chk(amp_gain, 8'h14);
      exp_run(1'b0, 1'b1, 700);
      chk({integ_time, amp_gain}, {16'h0001, 8'h00});
      chk(exp_bad, 0);
      i_host.rd(6'h17, d, r);
      chk(d, 32'h0);
      // A zero floor can never be undercut, so raise it above the gain
      cfg(6'h18, 8'h04);
      exp_run(1'b0, 1'b1, 3);
      chk(amp_gain, 8'h04);
      auto_exposure_en <= 1'b0;
   endtask : t_exposure

   task automatic t_regs;
      logic [31:0] d;
      logic [1:0] r;
      for (int i = 0; i < SRG_NREG; i++)
         cfg(SRG_IDX[i], 8'hA5);
      rb(1'b0);
      chk({red_gain, green_gain, blue_gain}, {3{6'h25}});
      chk(amp_gain, 8'hA5);
      chk({pixel_bias, amp_bias}, 6'h25);
      chk(clamp_level, 4'h5);
      chk(adc_bias, 4'h5);
      i_host.wr(6'h1D, 8'h00, r);
      chk(r, SRG_RESP_SLVERR);
      i_host.rd(6'h1D, d, r);
      chk({r, d}, {SRG_RESP_SLVERR, 32'h0});
   endtask : t_regs

   initial
   begin
      repeat (4) @(posedge ref_clk);
      resetn <= 1'b1;
      chk(integ_time, SRG_ITIME_RST);
      chk({red_gain, green_gain, blue_gain}, {3{6'h10}});
      chk(amp_gain, 8'h10);
      chk({pixel_bias, amp_bias}, 6'h13);
      chk(clamp_level, 4'h7);
      chk(adc_bias, 4'hF);
      rb(1'b1);
      t_video();
      t_exposure();
      t_regs();
      print_verdict();
   end

   // Whole run needs under 10000 cycles; 60000 leaves margin
   initial
   begin
      #1500000;
      n_errors++;
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire

// *** verilog/srg_pkg.sv ***
// Register map, field layout and timing constants of the sensor readout register bank
package srg_pkg;
   localparam int SRG_NREG = 22;
   localparam int SRG_AW = 8;
   localparam int SRG_DW = 32;
   // Printed register indices; byte address is four times the index
   localparam logic [5:0] SRG_IDX [SRG_NREG] = '{6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0D,
      6'h0E, 6'h0F, 6'h10, 6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h16, 6'h17, 6'h18, 6'h19,
      6'h1A, 6'h1B, 6'h1C, 6'h20};
   localparam logic [7:0] SRG_MASK [SRG_NREG] = '{8'h01, 8'hFF, 8'h03, 8'hFF, 8'h01, 8'hFF,
      8'h03, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'h3F, 8'h3F, 8'hFF, 8'hFF, 8'hFF,
      8'hFF, 8'h3F, 8'h0F, 8'h0F};
   localparam logic [7:0] SRG_RST [SRG_NREG] = '{8'h00, 8'h02, 8'h00, 8'h02, 8'h01, 8'hE0,
      8'h02, 8'h80, 8'h00, 8'hD0, 8'h00, 8'h08, 8'h10, 8'h10, 8'h10, 8'h10, 8'h00, 8'h3F,
      8'h10, 8'h13, 8'h07, 8'h0F};
   // Slots in the register array
   localparam int SRG_S_ROW_HI = 0;
   localparam int SRG_S_ROW_LO = 1;
   localparam int SRG_S_COL_HI = 2;
   localparam int SRG_S_COL_LO = 3;
   localparam int SRG_S_ROWS_HI = 4;
   localparam int SRG_S_ROWS_LO = 5;
   localparam int SRG_S_COLS_HI = 6;
   localparam int SRG_S_COLS_LO = 7;
   localparam int SRG_S_LGAP_HI = 8;
   localparam int SRG_S_LGAP_LO = 9;
   localparam int SRG_S_FGAP_HI = 10;
   localparam int SRG_S_FGAP_LO = 11;
   localparam int SRG_S_RED = 12;
   localparam int SRG_S_GREEN = 13;
   localparam int SRG_S_BLUE = 14;
   localparam int SRG_S_AMP = 15;
   localparam int SRG_S_FLOOR = 16;
   localparam int SRG_S_CEIL = 17;
   localparam int SRG_S_REF = 18;
   localparam int SRG_S_BIAS = 19;
   localparam int SRG_S_CLAMP = 20;
   localparam int SRG_S_ADC = 21;
   // Field positions of the analog bias register, and widths of the bias, colour gain and nibble fields
   localparam int SRG_PIXB_LSB = 3;
   localparam int SRG_AMPB_LSB = 0;
   localparam int SRG_BIAS_W = 3;
   localparam int SRG_CGAIN_W = 6;
   localparam int SRG_NIB_W = 4;
   // AXI responses
   localparam logic [1:0] SRG_RESP_OKAY = 2'h0;
   localparam logic [1:0] SRG_RESP_SLVERR = 2'h2;
   // Sensor clock is the reference clock over two
   localparam int SRG_SENS_DIV = 2;
   localparam logic [15:0] SRG_ITIME_MIN = 16'h0001;
   localparam logic [15:0] SRG_ITIME_MAX = 16'h0200;
   localparam logic [15:0] SRG_ITIME_RST = 16'h0100;
   typedef enum logic {SRG_ST_ACT = 1'b0, SRG_ST_GAP = 1'b1} srg_tg_state_t;
endpackage : srg_pkg

// *** verilog/srg_regs.sv ***
// Sensor readout window, blanking, gain and bias register bank with AXI4-Lite access
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Readout starts at row formed from row high and low registers, default 2.
// - Readout starts at column formed from column high and low registers.
// - Rows read per frame equal the programmed window height.
// - Pixels read per line equal the programmed window width.
// - Line gap between lines lasts the programmed count of sensor clocks.
// - Vertical sync stays high for the programmed frame gap time.
// - Vertical sync rises only at the boundary between consecutive frames.
// - Colour gains are six-bit codes, gain 0.5 plus code/32, unity at reset.
// - Common amplifier gain is an eight-bit code, gain 0.5 plus code/16.
// - Auto exposure never drives amplifier gain below the floor register; it can when the floor is set above the ceiling.
// - Auto exposure never drives amplifier gain above the ceiling register; it can when the floor is set above the ceiling.
// - Exposure moves integration time first, then gain from the reference value.
// - Bias register holds pixel and amplifier bias fields, driven to analog circuits.
// - Reset clamp holds a four-bit level, default 7, driven to the clamp.
// - Converter bias holds a four-bit current, default 0Fh, driven out.
// - Vertical sync equals vertical blank; horizontal sync is inverted horizontal blank.
module srg_regs
   import srg_pkg::*;
#(
   parameter int SENS_DIV = SRG_SENS_DIV
)
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [SRG_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [SRG_DW-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [SRG_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [SRG_DW-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic auto_exposure_en,
   input wire logic exp_more,
   input wire logic exp_less,
   output logic vsync,
   output logic hsync,
   output logic pix_valid,
   output logic [8:0] row_addr,
   output logic [9:0] col_addr,
   output logic [SRG_CGAIN_W-1:0] red_gain,
   output logic [SRG_CGAIN_W-1:0] green_gain,
   output logic [SRG_CGAIN_W-1:0] blue_gain,
   output logic [7:0] amp_gain,
   output logic [SRG_BIAS_W-1:0] pixel_bias,
   output logic [SRG_BIAS_W-1:0] amp_bias,
   output logic [SRG_NIB_W-1:0] clamp_level,
   output logic [SRG_NIB_W-1:0] adc_bias,
   output logic [15:0] integ_time
);
   logic [7:0] regs_ff [SRG_NREG];
   logic wr_fire, wr_hit, rd_hit;
   logic [4:0] wr_slot, rd_slot;
   logic [SRG_DW-1:0] nxt_rdata;
   logic exp_wr;
   logic [7:0] exp_val;

   // Write and read address decode
   always_comb
   begin
      wr_hit = 1'b0;
      wr_slot = 5'h00;
      rd_hit = 1'b0;
      rd_slot = 5'h00;
      for (int k = 0; k < SRG_NREG; k++)
      begin
         if (s_axi_awaddr == {SRG_IDX[k], 2'h0})
         begin
            wr_hit = 1'b1;
            wr_slot = 5'(k);
         end
         if (s_axi_araddr == {SRG_IDX[k], 2'h0})
         begin
            rd_hit = 1'b1;
            rd_slot = 5'(k);
         end
      end
   end

   // Address and data are taken together, so neither can be orphaned
   assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign s_axi_wready = s_axi_awready;
   assign wr_fire = s_axi_awready;
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= SRG_RESP_OKAY;
      end
      else if (wr_fire)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? SRG_RESP_OKAY : SRG_RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_comb
   begin
      nxt_rdata = '0;
      if (rd_hit)
      begin
         nxt_rdata[7:0] = regs_ff[rd_slot] & SRG_MASK[rd_slot];
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= SRG_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= nxt_rdata;
         s_axi_rresp <= rd_hit ? SRG_RESP_OKAY : SRG_RESP_SLVERR;
      end
      else if (s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // One register per entry; the exposure loop wins over a write in the same cycle
   for (genvar g = 0; g < SRG_NREG; g++)
   begin : g_reg
      always_ff @(posedge ref_clk)
      begin
         if (!resetn)
         begin
            regs_ff[g] <= SRG_RST[g];
         end
         else if (g == SRG_S_AMP && exp_wr)
         begin
            regs_ff[g] <= exp_val;
         end
         else if (wr_fire && wr_hit && wr_slot == 5'(g) && s_axi_wstrb[0])
         begin
            regs_ff[g] <= s_axi_wdata[7:0] & SRG_MASK[g];
         end
      end
   end

   // Joined multi-byte values
   logic [8:0] row_first;
   logic [9:0] col_first;
   logic [8:0] rows_cnt;
   logic [9:0] cols_cnt;
   logic [15:0] line_gap, frame_gap;
   assign row_first = {regs_ff[SRG_S_ROW_HI][0], regs_ff[SRG_S_ROW_LO]};
   assign col_first = {regs_ff[SRG_S_COL_HI][1:0], regs_ff[SRG_S_COL_LO]};
   assign rows_cnt = {regs_ff[SRG_S_ROWS_HI][0], regs_ff[SRG_S_ROWS_LO]};
   assign cols_cnt = {regs_ff[SRG_S_COLS_HI][1:0], regs_ff[SRG_S_COLS_LO]};
   assign line_gap = {regs_ff[SRG_S_LGAP_HI], regs_ff[SRG_S_LGAP_LO]};
   assign frame_gap = {regs_ff[SRG_S_FGAP_HI], regs_ff[SRG_S_FGAP_LO]};

   // Analog settings straight from the registers
   assign red_gain = regs_ff[SRG_S_RED][SRG_CGAIN_W-1:0];
   assign green_gain = regs_ff[SRG_S_GREEN][SRG_CGAIN_W-1:0];
   assign blue_gain = regs_ff[SRG_S_BLUE][SRG_CGAIN_W-1:0];
   assign amp_gain = regs_ff[SRG_S_AMP];
   assign pixel_bias = regs_ff[SRG_S_BIAS][SRG_PIXB_LSB +: SRG_BIAS_W];
   assign amp_bias = regs_ff[SRG_S_BIAS][SRG_AMPB_LSB +: SRG_BIAS_W];
   assign clamp_level = regs_ff[SRG_S_CLAMP][SRG_NIB_W-1:0];
   assign adc_bias = regs_ff[SRG_S_ADC][SRG_NIB_W-1:0];

   // Sensor clock enable
   logic [7:0] div_ff;
   logic sen;
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         div_ff <= 8'h00;
      end
      else
      begin
         div_ff <= (div_ff == 8'(SENS_DIV - 1)) ? 8'h00 : div_ff + 8'h01;
      end
   end
   assign sen = (div_ff == 8'(SENS_DIV - 1));

   // Readout timing; a zero count is treated as one so a line never stalls
   srg_tg_state_t state_ff;
   logic frame_gap_hi_ff;
   logic [15:0] pos_ff, line_ff;
   logic [15:0] cols_eff, gap_eff, rows_eff, fgap_eff;
   logic line_end, hblank;
   assign cols_eff = (cols_cnt == 10'h000) ? 16'h0001 : {6'h00, cols_cnt};
   assign gap_eff = (line_gap == 16'h0000) ? 16'h0001 : line_gap;
   assign rows_eff = (rows_cnt == 9'h000) ? 16'h0001 : {7'h00, rows_cnt};
   assign fgap_eff = (frame_gap == 16'h0000) ? 16'h0001 : frame_gap;
   assign line_end = sen && state_ff == SRG_ST_GAP && pos_ff + 16'h0001 >= gap_eff;

   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         state_ff <= SRG_ST_GAP;
         pos_ff <= 16'h0000;
      end
      else if (sen)
      begin
         case (state_ff)
            SRG_ST_ACT:
            begin
               if (pos_ff + 16'h0001 >= cols_eff)
               begin
                  state_ff <= SRG_ST_GAP;
                  pos_ff <= 16'h0000;
               end
               else
               begin
                  pos_ff <= pos_ff + 16'h0001;
               end
            end
            SRG_ST_GAP:
            begin
               if (line_end)
               begin
                  state_ff <= SRG_ST_ACT;
                  pos_ff <= 16'h0000;
               end
               else
               begin
                  pos_ff <= pos_ff + 16'h0001;
               end
            end
            default:
            begin
               state_ff <= SRG_ST_GAP;
            end
         endcase
      end
   end

   // Frame gap counted in line periods; the frame starts in its blank
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         frame_gap_hi_ff <= 1'b1;
         line_ff <= 16'h0000;
      end
      else if (line_end)
      begin
         if (frame_gap_hi_ff && line_ff + 16'h0001 >= fgap_eff)
         begin
            frame_gap_hi_ff <= 1'b0;
            line_ff <= 16'h0000;
         end
         else if (!frame_gap_hi_ff && line_ff + 16'h0001 >= rows_eff)
         begin
            frame_gap_hi_ff <= 1'b1;
            line_ff <= 16'h0000;
         end
         else
         begin
            line_ff <= line_ff + 16'h0001;
         end
      end
   end

   assign hblank = frame_gap_hi_ff || state_ff != SRG_ST_ACT;
   assign vsync = frame_gap_hi_ff;
   assign hsync = !hblank;
   assign pix_valid = !hblank;
   assign row_addr = row_first + line_ff[8:0];
   assign col_addr = col_first + pos_ff[9:0];

   // Exposure loop: integration time first, amplifier gain only at its bounds
   logic gain_mode_ff;
   logic [15:0] itime_ff;
   logic [7:0] amp_cur, amp_lo, amp_hi, ref_cl;
   logic exp_step;
   assign amp_cur = regs_ff[SRG_S_AMP];
   assign amp_lo = regs_ff[SRG_S_FLOOR];
   assign amp_hi = regs_ff[SRG_S_CEIL];
   assign ref_cl = (regs_ff[SRG_S_REF] < amp_lo) ? amp_lo :
                   (regs_ff[SRG_S_REF] > amp_hi) ? amp_hi : regs_ff[SRG_S_REF];
   assign exp_step = auto_exposure_en && (exp_more ^ exp_less);
   assign integ_time = itime_ff;

   always_comb
   begin
      exp_wr = 1'b0;
      exp_val = amp_cur;
      if (exp_step && !gain_mode_ff &&
          ((exp_more && itime_ff >= SRG_ITIME_MAX) || (exp_less && itime_ff <= SRG_ITIME_MIN)))
      begin
         exp_wr = 1'b1;
         exp_val = ref_cl;
      end
      else if (exp_step && gain_mode_ff)
      begin
         exp_wr = 1'b1;
         if (exp_more)
         begin
            exp_val = (amp_cur >= amp_hi) ? amp_hi :
                      (amp_cur < amp_lo) ? amp_lo : amp_cur + 8'h01;
         end
         else
         begin
            exp_val = (amp_cur <= amp_lo) ? amp_lo :
                      (amp_cur > amp_hi) ? amp_hi : amp_cur - 8'h01;
         end
      end
   end

   // Gain returns to the reference before integration time moves again
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         gain_mode_ff <= 1'b0;
         itime_ff <= SRG_ITIME_RST;
      end
      else if (exp_step)
      begin
         if (!gain_mode_ff)
         begin
            if (exp_more && itime_ff < SRG_ITIME_MAX)
            begin
               itime_ff <= itime_ff + 16'h0001;
            end
            else if (exp_less && itime_ff > SRG_ITIME_MIN)
            begin
               itime_ff <= itime_ff - 16'h0001;
            end
            else
            begin
               gain_mode_ff <= 1'b1;
            end
         end
         else if ((exp_less && itime_ff >= SRG_ITIME_MAX && amp_cur <= ref_cl) ||
                  (exp_more && itime_ff <= SRG_ITIME_MIN && amp_cur >= ref_cl))
         begin
            gain_mode_ff <= 1'b0;
         end
      end
   end

   // Checks
   logic [15:0] pix_run_ff, gap_run_ff, row_run_ff, vline_run_ff;
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         pix_run_ff <= 16'h0000;
         gap_run_ff <= 16'h0000;
         row_run_ff <= 16'h0000;
         vline_run_ff <= 16'h0000;
      end
      else
      begin
         if (sen && state_ff == SRG_ST_ACT)
         begin
            pix_run_ff <= pix_run_ff + 16'h0001;
         end
         else if (state_ff == SRG_ST_GAP)
         begin
            pix_run_ff <= 16'h0000;
         end
         if (sen && state_ff == SRG_ST_GAP)
         begin
            gap_run_ff <= gap_run_ff + 16'h0001;
         end
         else if (state_ff == SRG_ST_ACT)
         begin
            gap_run_ff <= 16'h0000;
         end
         if (line_end && !frame_gap_hi_ff)
         begin
            row_run_ff <= row_run_ff + 16'h0001;
         end
         else if (frame_gap_hi_ff)
         begin
            row_run_ff <= 16'h0000;
         end
         if (line_end && frame_gap_hi_ff)
         begin
            vline_run_ff <= vline_run_ff + 16'h0001;
         end
         else if (!frame_gap_hi_ff)
         begin
            vline_run_ff <= 16'h0000;
         end
      end
   end

   a_row_first: assert property (@(posedge ref_clk) disable iff (!resetn)
      $rose(pix_valid) && line_ff == 16'h0000 |-> row_addr == row_first)
      else $error("first row of frame not at row start");
   a_col_first: assert property (@(posedge ref_clk) disable iff (!resetn)
      $rose(pix_valid) |-> col_addr == col_first)
      else $error("line does not begin at column start");
   a_line_width: assert property (@(posedge ref_clk) disable iff (!resetn)
      $fell(state_ff == SRG_ST_ACT) |-> pix_run_ff == cols_eff)
      else $error("pixels per line differ from width");
   a_gap_length: assert property (@(posedge ref_clk) disable iff (!resetn)
      $fell(state_ff == SRG_ST_GAP) |-> gap_run_ff == gap_eff)
      else $error("line gap length wrong");
   a_frame_height: assert property (@(posedge ref_clk) disable iff (!resetn)
      $rose(vsync) |-> $past(row_run_ff) + 16'h0001 == rows_eff)
      else $error("rows per frame differ from height");
   a_vsync_span: assert property (@(posedge ref_clk) disable iff (!resetn)
      $fell(vsync) |-> $past(vline_run_ff) + 16'h0001 == fgap_eff)
      else $error("vertical sync length wrong");
   a_vsync_edge: assert property (@(posedge ref_clk) disable iff (!resetn)
      $rose(vsync) |-> $past(state_ff == SRG_ST_GAP) && $past(line_end) && !hsync)
      else $error("vertical sync rose inside a frame");
   a_sync_pair: assert property (@(posedge ref_clk) disable iff (!resetn)
      vsync |-> !hsync && !pix_valid)
      else $error("horizontal sync active in vertical blank");
   a_gain_floor: assert property (@(posedge ref_clk) disable iff (!resetn)
      exp_wr && exp_less && amp_lo <= amp_hi |=> amp_gain >= $past(amp_lo))
      else $error("gain driven below floor");
   a_gain_ceiling: assert property (@(posedge ref_clk) disable iff (!resetn)
      exp_wr && exp_more && amp_lo <= amp_hi |=> amp_gain <= $past(amp_hi))
      else $error("gain driven above ceiling");
   a_gain_reference: assert property (@(posedge ref_clk) disable iff (!resetn)
      exp_step && !gain_mode_ff && !(exp_more && itime_ff < SRG_ITIME_MAX)
      && !(exp_less && itime_ff > SRG_ITIME_MIN) |=> gain_mode_ff && amp_gain == $past(ref_cl))
      else $error("gain phase did not start at reference");
   a_time_first: assert property (@(posedge ref_clk) disable iff (!resetn)
      exp_step && !gain_mode_ff && exp_more && itime_ff < SRG_ITIME_MAX
      && !(wr_fire && wr_hit) |=> $stable(amp_gain) && itime_ff == $past(itime_ff) + 16'h0001)
      else $error("gain moved before integration time bound");
   a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_axi_rvalid |-> s_axi_rdata[SRG_DW-1:8] == '0)
      else $error("reserved read bits not zero");
endmodule : srg_regs
`default_nettype wire
